//--- verilog/cbd_decoder.sv
// Configuration byte decoder and debug gate: reloads control bits after each
// reset, guards programmer access under lock and gates debugger accesses.
// Assumes reset request pulses and halt status come from the core on clk.
`include "cbd_params.svh"
`default_nettype none

module cbd_decoder
	import cbd_pkg::*;
#(
	parameter int PWM_CH = 6 // Number of PWM channels
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Reset events from the reset logic
	input  wire logic              reload_req,
	input  wire cbd_pkg::cbd_rst_src_t reload_src,
	// Flash access from programming paths
	input  wire logic              fl_req,
	input  wire logic              fl_write,
	input  wire cbd_pkg::cbd_path_t fl_path,
	input  wire logic              fl_is_cfg,
	input  wire logic              fl_cfg_addr,
	input  wire logic        [7:0] fl_wdata,
	input  wire logic        [7:0] fl_array_rdata,
	input  wire logic              chip_erase,
	output logic                   fl_array_we,
	output logic             [7:0] fl_rdata,
	// Software control bits
	input  wire logic              sw_boot_we,
	input  wire logic              sw_boot_val,
	output logic                   runtime_boot_region,
	// CPU and debugger status
	input  wire logic              cpu_halted,
	input  wire logic              cpu_idle_or_pd,
	input  wire logic              dbg_req,
	input  wire logic              hard_fault,
	input  wire logic              osc_off_req,
	input  wire logic [PWM_CH-1:0] pwm_pin_output_enable,
	output logic                   dbg_grant,
	output logic                   hard_fault_reset,
	output logic                   hard_fault_flag,
	output logic                   fast_internal_oscillator,
	output logic       [PWM_CH-1:0] pwm_tristate,
	output logic                   debug_active,
	output logic                   debug_pins_owned,
	// Decoded configuration
	output logic                   reset_pin_function_select,
	output logic             [4:0] loader_kb,
	output logic             [4:0] main_kb,
	output logic                   boot_from_loader
);
	// Block state in one struct; the reset sync flops stay outside
	typedef struct packed {
		logic       rd_cfg;   // Last read aimed at a config byte
		logic       boot;     // Runtime boot region, 1 = loader
		logic       pwmtri;   // Latched tristate select
		logic       dbg_n;    // Latched debug enable, low active
		logic       rstpin;   // Latched reset pin function
		logic       lock_n;   // Latched lock bit, 0 = locked
		logic [2:0] loader_rom_size;   // Latched loader size field
		logic       hff;      // Hard fault flag
		logic       osc;      // Oscillator on
		logic [7:0] rdata;    // Registered read data
	} cbd_state_t;

	cbd_state_t s_r;   // Registered state
	cbd_state_t s_nxt; // Next state
	logic       srst_n; // Synchronised reset
	logic [1:0] rsync_r; // Reset sync stages, bit 0 first
	logic [7:0] cfg0;
	logic [7:0] cfg1;
	logic [7:0] cfg_rd;
	logic       cfg_we;
	logic       ext_path;

	// Loader size decode used for both loader and main sizes
	function automatic logic [4:0] ld_kb(input logic [2:0] f);
		unique casez (f)
			3'b111: ld_kb = 5'h00;
			3'b110: ld_kb = 5'h01;
			3'b101: ld_kb = 5'h02;
			3'b100: ld_kb = 5'h03;
			default: ld_kb = `CBD_LOADER_MAX_KB;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops, kept apart from the state struct
	// because it runs on the raw reset and ignores the clock enable
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rsync_r <= 2'h0;
		else
			rsync_r <= {rsync_r[0], 1'b1};
	end
	assign srst_n = rsync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// Access steering
	assign ext_path = (fl_path != CBD_PATH_APP);
	// Locked: external config programming ignored, app path unaffected
	assign cfg_we = fl_req && fl_write && fl_is_cfg && !chip_erase
		&& !(ext_path && !s_r.lock_n);
	// Locked: external array programming dropped
	assign fl_array_we = fl_req && fl_write && !fl_is_cfg
		&& !(ext_path && !s_r.lock_n);

	// Config byte store
	cbd_cfg_store u_store (
		.clk       (clk),
		.rst_n     (srst_n),
		.ce        (ce),
		.wr_en     (cfg_we),
		.addr      (fl_cfg_addr),
		.wr_data   (fl_wdata),
		.erase_all (chip_erase),
		.rd_data   (cfg_rd),
		.byte0     (cfg0),
		.byte1     (cfg1)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		s_nxt     = s_r;
		// Reload latches only on a reset event, held otherwise except boot on a software write and osc on an off request
		if (reload_req)
		begin
			s_nxt.pwmtri = cfg0[`CBD_PWMTRI_BIT];
			s_nxt.dbg_n  = cfg0[`CBD_DBGEN_N_BIT];
			s_nxt.rstpin = cfg0[`CBD_RSTPIN_BIT];
			s_nxt.lock_n = cfg0[`CBD_LOCK_BIT];
			s_nxt.loader_rom_size = cfg1[2:0];
			s_nxt.osc    = 1'b1;
			// Software reset keeps the runtime boot choice
			if (reload_src != CBD_RST_SOFT)
				s_nxt.boot = ~cfg0[`CBD_BOOT_BIT];
		end
		else if (sw_boot_we)
			s_nxt.boot = sw_boot_val;
		// Oscillator off request ignored while debugging
		if (osc_off_req && !debug_active)
			s_nxt.osc = 1'b0;
		// Flag set on any hard fault; set wins
		if (hard_fault)
			s_nxt.hff = 1'b1;
		else if (reload_req)
			s_nxt.hff = 1'b0;
		// Config reads come from the store's own read register, so both
		// kinds of read answer one cycle after the request
		s_nxt.rd_cfg = fl_is_cfg;
		// Locked external array reads come back blank
		if (ext_path && !s_r.lock_n)
			s_nxt.rdata = `CBD_BLANK_BYTE;
		else
			s_nxt.rdata = fl_array_rdata;
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			s_r.rd_cfg <= 1'b0;
			s_r.boot   <= 1'b0;
			s_r.pwmtri <= 1'b1;
			s_r.dbg_n  <= 1'b1;
			s_r.rstpin <= 1'b1;
			s_r.lock_n <= 1'b0;
			s_r.loader_rom_size <= 3'h7;
			s_r.hff    <= 1'b0;
			s_r.osc    <= 1'b1;
			s_r.rdata  <= 8'h00;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// Debug needs enable low and chip unlocked
	assign debug_active = !s_r.dbg_n && s_r.lock_n;
	assign debug_pins_owned = debug_active;
	// Halted only; idle or power-down accesses are also refused for safety
	assign dbg_grant = debug_active && dbg_req && cpu_halted
		&& !cpu_idle_or_pd;
	// Hard fault resets only outside debug
	assign hard_fault_reset = hard_fault && !debug_active;
	assign hard_fault_flag = s_r.hff;
	// Oscillator held on in debug even in power-down
	assign fast_internal_oscillator = s_r.osc || debug_active;
	assign pwm_tristate = (debug_active && cpu_halted && s_r.pwmtri)
		? pwm_pin_output_enable : '0;
	assign reset_pin_function_select = s_r.rstpin;
	assign loader_kb = ld_kb(s_r.loader_rom_size);
	assign main_kb = `CBD_FLASH_KB - ld_kb(s_r.loader_rom_size);
	assign runtime_boot_region = s_r.boot;
	assign boot_from_loader = s_r.boot;
	assign fl_rdata = s_r.rd_cfg ? cfg_rd : s_r.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_boot_reload: assert property (@(posedge clk) disable iff (!srst_n)
		ce && reload_req && reload_src != CBD_RST_SOFT |=> boot_from_loader == !$past(cfg0[7]))
		else $error("boot bit not reloaded inverted");
	a_soft_keep: assert property (@(posedge clk) disable iff (!srst_n)
		ce && reload_req && reload_src == CBD_RST_SOFT |=> $stable(runtime_boot_region))
		else $error("soft reset changed boot bit");
	a_lock_blank: assert property (@(posedge clk) disable iff (!srst_n)
		ce && !fl_is_cfg && ext_path && !s_r.lock_n |=> fl_rdata == 8'hff)
		else $error("locked read not blank");
	a_lock_nowr: assert property (@(posedge clk) disable iff (!srst_n)
		!s_r.lock_n && ext_path |-> !fl_array_we)
		else $error("locked write passed");
	a_dbg_halt: assert property (@(posedge clk) disable iff (!srst_n)
		dbg_grant |-> cpu_halted && debug_active)
		else $error("debug access while running");
	a_hf_noreset: assert property (@(posedge clk) disable iff (!srst_n)
		debug_active && hard_fault |-> !hard_fault_reset ##1 (hard_fault_flag || !$past(ce)))
		else $error("hard fault reset in debug");
	a_osc_on: assert property (@(posedge clk) disable iff (!srst_n)
		debug_active |-> fast_internal_oscillator)
		else $error("oscillator off in debug");
	a_size_sum: assert property (@(posedge clk) disable iff (!srst_n)
		loader_kb + main_kb == 5'h12)
		else $error("flash split wrong");
	a_held_cfg: assert property (@(posedge clk) disable iff (!srst_n)
		!reload_req ##1 1'b1 |-> $stable(reset_pin_function_select))
		else $error("config changed without reload");
	c_reload: cover property (@(posedge clk) disable iff (!srst_n) reload_req && ce);
	c_grant: cover property (@(posedge clk) disable iff (!srst_n) dbg_grant);
	c_tri: cover property (@(posedge clk) disable iff (!srst_n) |pwm_tristate);
endmodule
`default_nettype wire

//--- verilog/cbd_params.svh
// Constants for the configuration byte decoder: bit positions, reset values, sizes.
// Assumes inclusion by bare name from the design modules.
`ifndef CBD_PARAMS_SVH
`define CBD_PARAMS_SVH

// Boot, debug and lock byte field positions
`define CBD_BOOT_BIT      7
`define CBD_PWMTRI_BIT    5
`define CBD_DBGEN_N_BIT   4
`define CBD_RSTPIN_BIT    2
`define CBD_LOCK_BIT      1
// Factory (erased) value of every configuration byte
`define CBD_ERASED_BYTE   8'hff
// Value returned for locked external flash array reads
`define CBD_BLANK_BYTE    8'hff
// Total flash size in kilobytes and largest loader size
`define CBD_FLASH_KB      5'h12
`define CBD_LOADER_MAX_KB 5'h04
// Number of configuration bytes held
`define CBD_NUM_CFG       2
// Reserved bits of the boot byte and loader byte kept at one
`define CBD_RSVD0_MASK    8'h49
`define CBD_RSVD1_MASK    8'hf8

`endif

//--- verilog/cbd_pkg.sv
// Types shared by the configuration byte decoder files.
// Assumes cbd_params.svh sits on the include path.
`default_nettype none
package cbd_pkg;
	// Reload source: software reset keeps the runtime boot bit
	typedef enum logic [1:0] {
		CBD_RST_POWER,
		CBD_RST_PIN,
		CBD_RST_SOFT,
		CBD_RST_OTHER
	} cbd_rst_src_t;
	// Programming path selector for flash accesses
	typedef enum logic [1:0] {
		CBD_PATH_WRITER,
		CBD_PATH_SERIAL,
		CBD_PATH_APP
	} cbd_path_t;
endpackage
`default_nettype wire

//--- verilog/cbd_cfg_store.sv
// Configuration byte store, erased on reset, with registered read data.
// Assumes erase and write strobes come from the decoder on the same clock.
`include "cbd_params.svh"
`default_nettype none
module cbd_cfg_store
	import cbd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Access port
	input  wire logic       wr_en,
	input  wire logic       addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       erase_all,
	output logic      [7:0] rd_data,
	// Always-visible copies for the decoder
	output logic      [7:0] byte0,
	output logic      [7:0] byte1
);
	// Whole store state in one struct
	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] rd;
	} cbd_store_t;

	cbd_store_t st_r;   // Registered state
	cbd_store_t st_nxt; // Next state

	////////////////////////////////////////////////////////////////////////////
	// Next state: erase wins over a byte write
	always_comb
	begin
		st_nxt = st_r;
		if (erase_all)
		begin
			st_nxt.b0 = `CBD_ERASED_BYTE;
			st_nxt.b1 = `CBD_ERASED_BYTE;
		end
		else if (wr_en)
		begin
			// Reserved bits stay unprogrammed
			if (addr)
				st_nxt.b1 = wr_data | `CBD_RSVD1_MASK;
			else
				st_nxt.b0 = wr_data | `CBD_RSVD0_MASK;
		end
		st_nxt.rd = addr ? st_r.b1 : st_r.b0;
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r.b0 <= `CBD_ERASED_BYTE;
			st_r.b1 <= `CBD_ERASED_BYTE;
			st_r.rd <= 8'h00;
		end
		else if (ce)
			st_r <= st_nxt;
	end

	assign rd_data = st_r.rd;
	assign byte0   = st_r.b0;
	assign byte1   = st_r.b1;
endmodule
`default_nettype wire

//--- testbench/cbd_flash_model.sv
// Flash array model behind the programming paths.
// Assumes the decoder gates writes through its array write enable.
`default_nettype none
module cbd_flash_model
(
	// Clock
	input  wire logic       clk,
	// Array access
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic       erase,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_r  = 8'h5a; // Stored array byte
	logic [7:0] last_r = 8'h00; // Last value shown
	// Not requested: show a flipped value so stale data never matches
	assign rdata = req ? mem_r : ~last_r;
	// Whole-chip erase blanks the array; else only an enabled write lands
	always_ff @(posedge clk)
	begin
		if (erase)
			mem_r <= 8'hff;
		else if (req && we)
			mem_r <= wdata;
		last_r <= rdata;
	end
endmodule
`default_nettype wire

//--- testbench/config_byte_decode_debug_gate_tb.sv
// Self-checking bench for the configuration decoder and debug gate.
// Assumes cbd_pkg and cbd_flash_model are compiled first.
`default_nettype none
module config_byte_decode_debug_gate_tb;
	import cbd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, ce = 1, rld = 0, fr = 0, fw = 0, fc = 0, fa = 0;
	logic ers = 0, swe = 0, sv = 0, halt = 0, idle = 0, dreq = 0, hf = 0, osc = 0;
	cbd_rst_src_t src = CBD_RST_POWER;
	cbd_path_t    path = CBD_PATH_SERIAL;
	logic [7:0]   wd = 8'h00, ard, rd, rd_s;
	logic [5:0]   pen = 6'h00, ptri;
	logic [4:0]   lkb, mkb, ld;
	logic         awe, we_s, rbr, grant, hfr, hff, fio, dact, down, rpin, bfl;
	int           mismatches = 0, checks_done = 0;
	// Design and array model
	cbd_decoder #(.PWM_CH(6)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reload_req(rld), .reload_src(src), .fl_req(fr), .fl_write(fw),
		.fl_path(path), .fl_is_cfg(fc), .fl_cfg_addr(fa), .fl_wdata(wd),
		.fl_array_rdata(ard), .chip_erase(ers), .fl_array_we(awe), .fl_rdata(rd),
		.sw_boot_we(swe), .sw_boot_val(sv), .runtime_boot_region(rbr),
		.cpu_halted(halt), .cpu_idle_or_pd(idle), .dbg_req(dreq), .hard_fault(hf),
		.osc_off_req(osc), .pwm_pin_output_enable(pen), .dbg_grant(grant),
		.hard_fault_reset(hfr), .hard_fault_flag(hff), .fast_internal_oscillator(fio),
		.pwm_tristate(ptri), .debug_active(dact), .debug_pins_owned(down),
		.reset_pin_function_select(rpin), .loader_kb(lkb), .main_kb(mkb),
		.boot_from_loader(bfl));
	cbd_flash_model fm (.clk(clk), .req(fr), .we(awe), .erase(ers), .wdata(wd),
		.rdata(ard));
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial
	begin
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////
	// Compare, reload and flash access helpers
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic reload(input cbd_rst_src_t s);
		@(posedge clk);
		rld <= 1'b1;
		src <= s;
		@(posedge clk);
		rld <= 1'b0;
		#1;
	endtask
	// Array write enable is combinational; read data lands one edge later
	task automatic acc(input logic w, input cbd_path_t p, input logic c, input logic a,
		input logic [7:0] d);
		@(posedge clk);
		fr <= 1'b1;
		fw <= w;
		path <= p;
		fc <= c;
		fa <= a;
		wd <= d;
		#50;
		we_s = awe;
		@(posedge clk);
		fr <= 1'b0;
		#1;
		rd_s = rd;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		reload(CBD_RST_POWER);
		// Erased bytes: main boot, reset pin, no debug
		chk("boot", 8'h00, 8'(rbr));
		chk("loader_boot", 8'h00, 8'(bfl));
		chk("rstpin", 8'h01, 8'(rpin));
		chk("dbg", 8'h00, 8'(dact));
		$display("test defaults done");
		// Every loader size code, held until the next reload
		for (int i = 0; i < 8; i++)
		begin
			ld = mkb;
			acc(1'b1, CBD_PATH_SERIAL, 1'b1, 1'b1, 8'hf8 | 8'(i));
			chk("main_held", 8'(ld), 8'(mkb));
			reload(CBD_RST_OTHER);
			ld = (i < 4) ? 5'h04 : 5'(7 - i);
			chk("loader_kb", 8'(ld), 8'(lkb));
			chk("main_kb", 8'(5'h12 - ld), 8'(mkb));
		end
		$display("test loader sizes done");
		// Loader boot, pin as port, debug on; reserved bits read as one
		acc(1'b1, CBD_PATH_SERIAL, 1'b1, 1'b0, 8'h6b);
		acc(1'b0, CBD_PATH_SERIAL, 1'b1, 1'b0, 8'h00);
		chk("cfg0", 8'h6b, rd_s);
		chk("rstpin_held", 8'h01, 8'(rpin));
		reload(CBD_RST_POWER);
		chk("boot", 8'h01, 8'(rbr));
		chk("loader_boot", 8'h01, 8'(bfl));
		chk("rstpin", 8'h00, 8'(rpin));
		chk("dbg", 8'h01, 8'(dact));
		chk("pins", 8'h01, 8'(down));
		// Software write, then soft and pin reloads
		@(posedge clk);
		swe <= 1'b1;
		@(posedge clk);
		swe <= 1'b0;
		#1;
		chk("sw_boot", 8'h00, 8'(rbr));
		reload(CBD_RST_SOFT);
		chk("soft_boot", 8'h00, 8'(rbr));
		reload(CBD_RST_PIN);
		chk("pin_boot", 8'h01, 8'(rbr));
		// Clock enable low freezes the boot bit against a software write
		@(posedge clk);
		ce <= 1'b0;
		swe <= 1'b1;
		@(posedge clk);
		ce <= 1'b1;
		swe <= 1'b0;
		#1;
		chk("ce_hold", 8'h01, 8'(rbr));
		$display("test boot select done");
		// Debugger gate, PWM tristate, hard fault, oscillator
		@(posedge clk);
		dreq <= 1'b1;
		pen <= 6'h05;
		#50;
		chk("grant_run", 8'h00, 8'(grant));
		chk("pwm_run", 8'h00, 8'(ptri));
		@(posedge clk);
		halt <= 1'b1;
		hf <= 1'b1;
		osc <= 1'b1;
		#50;
		chk("grant_halt", 8'h01, 8'(grant));
		chk("pwm_halt", 8'h05, 8'(ptri));
		chk("hf_reset", 8'h00, 8'(hfr));
		@(posedge clk);
		idle <= 1'b1;
		hf <= 1'b0;
		#50;
		chk("grant_idle", 8'h00, 8'(grant));
		chk("hf_flag", 8'h01, 8'(hff));
		chk("osc", 8'h01, 8'(fio));
		@(posedge clk);
		idle <= 1'b0;
		osc <= 1'b0;
		$display("test debug done");
		// Lock with debug enabled in the byte
		acc(1'b1, CBD_PATH_SERIAL, 1'b1, 1'b0, 8'hed);
		reload(CBD_RST_POWER);
		chk("dbg_locked", 8'h00, 8'(dact));
		for (int p = 0; p < 2; p++)
		begin
			acc(1'b1, cbd_path_t'(p), 1'b0, 1'b0, 8'h33);
			chk("array_we", 8'h00, 8'(we_s));
			acc(1'b0, cbd_path_t'(p), 1'b0, 1'b0, 8'h00);
			chk("array_rd", 8'hff, rd_s);
		end
		acc(1'b1, CBD_PATH_WRITER, 1'b1, 1'b0, 8'hff);
		acc(1'b0, CBD_PATH_WRITER, 1'b1, 1'b0, 8'h00);
		chk("cfg_locked", 8'hed, rd_s);
		acc(1'b1, CBD_PATH_APP, 1'b0, 1'b0, 8'h3c);
		chk("app_we", 8'h01, 8'(we_s));
		acc(1'b0, CBD_PATH_APP, 1'b0, 1'b0, 8'h00);
		chk("app_rd", 8'h3c, rd_s);
		@(posedge clk);
		hf <= 1'b1;
		#50;
		chk("hf_nodbg", 8'h01, 8'(hfr));
		@(posedge clk);
		hf <= 1'b0;
		ers <= 1'b1;
		@(posedge clk);
		ers <= 1'b0;
		acc(1'b0, CBD_PATH_SERIAL, 1'b1, 1'b0, 8'h00);
		chk("erased", 8'hff, rd_s);
		reload(CBD_RST_POWER);
		// Array was blanked by the erase; unlocked serial path writes again
		acc(1'b1, CBD_PATH_SERIAL, 1'b0, 1'b0, 8'h3c);
		chk("unlocked_we", 8'h01, 8'(we_s));
		acc(1'b0, CBD_PATH_SERIAL, 1'b0, 1'b0, 8'h00);
		chk("unlocked_rd", 8'h3c, rd_s);
		$display("test lock done");
		stop_test();
	end
endmodule
`default_nettype wire
